// ==== iop_top.sv ====
// Purpose: Three configurable I/O ports with host registers
// Assumes: Host strobes and pins are synchronous to core_clk
// Notes: Overview of operation
// Overview of operation
// - Ports B and C have eight pins, port D three; each pin configured alone.
// - Per pin mux picks output value, array macrocell, or port D select term.
// - Driver enable is enable term OR direction bit, gated off for open drain pins driving high and for port C during programming.
// - Without enable term or array output, direction bit alone drives the enable.
// - Direction 1 is output, 0 input; all pins reset as inputs.
// - Pin input register reads the real pin level.
// - Written output value drives the pin; array-driven pins ignore it.
// - Output value readable and writable, pin input readable, at any time.
// - Bit n of each port register belongs to pin n of that port.
// - All port configuration registers reset to zero.
// - Each host read returns exactly one selected source.
// - Ports B and C inputs pass input macrocells: register, latch or pass.
// - Port D inputs reach the array directly.
// - B from AB group or BC group, C from BC group, D from select terms.
// - Array outputs tri-state when enable term and direction bit are both inactive, when open drain drives high, and on port C during programming.
// - In-system programming lives on port C only, shared otherwise.
// - Host reads levels, sets directions and levels through the registers.
// - Pin is input when direction and enable term are both inactive, when open drain drives high, or on port C during programming.
// - Only the low three direction bits of port D exist.
// - Drive select 1 means open drain or fast slew per pin; default push-pull.
`include "iop_consts.svh"

module iop_top
  import iop_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  // Host register port
  input wire logic host_sel,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  // Port B pins
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_fast,
  // Port C pins
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  output logic [7:0] port_c_fast,
  // Port D pins
  input wire logic [2:0] port_d_in,
  output logic [2:0] port_d_out,
  output logic [2:0] port_d_oe,
  output logic [2:0] port_d_fast,
  // Logic array side
  input wire logic [7:0] ab_macrocell_group,
  input wire logic [7:0] bc_macrocell_group,
  input wire logic [2:0] ext_select_terms,
  input wire logic [7:0] oe_term_b,
  input wire logic [7:0] oe_term_c,
  input wire logic [2:0] oe_term_d,
  input wire logic [7:0] b_array_out_sel,
  input wire logic [7:0] b_use_bc_group,
  input wire logic [7:0] c_array_out_sel,
  input wire logic [2:0] d_ext_select_sel,
  input wire logic [15:0] b_input_macrocell_mode,
  input wire logic [15:0] c_input_macrocell_mode,
  input wire logic b_imc_pt_lo,
  input wire logic b_imc_pt_hi,
  input wire logic c_imc_pt_lo,
  input wire logic c_imc_pt_hi,
  input wire logic in_system_programming,
  output logic [7:0] b_input_macrocell,
  output logic [7:0] c_input_macrocell,
  output logic [2:0] d_array_input
);

  iop_regs_t regs_reg;
  iop_regs_t regs_next;

  logic [7:0] b_array_val;
  logic [7:0] b_imc_q;
  logic [7:0] c_imc_q;
  logic [2:0] addr_reg_code;

  // Port D words padded to the bus width
  logic [7:0] d_pin_wide;
  logic [7:0] d_out_wide;
  logic [7:0] d_dir_wide;
  logic [7:0] d_drv_wide;
  logic [7:0] d_sel_wide;
  logic [7:0] d_arr_wide;

  // One candidate word per port; the read decode picks one of them
  logic [7:0] b_rd_word;
  logic [7:0] c_rd_word;
  logic [7:0] d_rd_word;

  // One source per read; unmapped codes read zero
  function automatic logic [7:0] iop_pick_source(
    input logic [2:0] reg_code,
    input logic [7:0] pin_level,
    input logic [7:0] out_val,
    input logic [7:0] dir_val,
    input logic [7:0] drv_val,
    input logic [7:0] omc_val,
    input logic [7:0] imc_val
  );
    logic [7:0] r;
    r = 8'h00;
    case (reg_code)
      `IOP_REG_PIN_INPUT: r = pin_level;
      `IOP_REG_OUTPUT_VALUE: r = out_val;
      `IOP_REG_DIRECTION: r = dir_val;
      `IOP_REG_DRIVE_CONFIG: r = drv_val;
      `IOP_REG_OMC_READBACK: r = omc_val;
      `IOP_REG_IMC_READBACK: r = imc_val;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // Port D has three pins; the missing upper bits always read zero
  function automatic logic [7:0] iop_pad_d(
    input logic [2:0] v
  );
    return {5'h00, v};
  endfunction

  // Port B may take either macrocell group per pin
  assign b_array_val = (b_use_bc_group & bc_macrocell_group) |
                       (~b_use_bc_group & ab_macrocell_group);

  assign addr_reg_code = host_addr[`IOP_ADDR_REG_HI:`IOP_ADDR_REG_LO];

  assign d_pin_wide = iop_pad_d(port_d_in);
  assign d_out_wide = iop_pad_d(regs_reg.out_d);
  assign d_dir_wide = iop_pad_d(regs_reg.dir_d);
  assign d_drv_wide = iop_pad_d(regs_reg.drv_d);
  assign d_sel_wide = iop_pad_d(ext_select_terms);
  assign d_arr_wide = iop_pad_d(regs_reg.d_array_in);

  // Each readback word places exactly one source on the bus
  assign b_rd_word = iop_pick_source(
    addr_reg_code,
    port_b_in,
    regs_reg.out_b,
    regs_reg.dir_b,
    regs_reg.drv_b,
    b_array_val,
    b_imc_q
  );

  assign c_rd_word = iop_pick_source(
    addr_reg_code,
    port_c_in,
    regs_reg.out_c,
    regs_reg.dir_c,
    regs_reg.drv_c,
    bc_macrocell_group,
    c_imc_q
  );

  assign d_rd_word = iop_pick_source(
    addr_reg_code,
    d_pin_wide,
    d_out_wide,
    d_dir_wide,
    d_drv_wide,
    d_sel_wide,
    d_arr_wide
  );

  always_comb begin
    logic [1:0] port_code;
    logic [2:0] reg_code;
    logic wr;
    logic rd;
    port_code = host_addr[`IOP_ADDR_PORT_HI:`IOP_ADDR_PORT_LO];
    reg_code = host_addr[`IOP_ADDR_REG_HI:`IOP_ADDR_REG_LO];
    wr = host_sel && host_wr;
    rd = host_sel && host_rd && !host_wr;
    regs_next = regs_reg;
    // Both strobes together count as a write only
    regs_next.rvalid = rd;
    // Port D pins enter the array with no macrocell in the way
    regs_next.d_array_in = port_d_in;

    // Writes land at the taking edge, with no wait state
    if (wr) begin
      case (port_code)
        `IOP_PORT_B: begin
          case (reg_code)
            `IOP_REG_OUTPUT_VALUE: regs_next.out_b = host_wdata;
            `IOP_REG_DIRECTION: regs_next.dir_b = host_wdata;
            `IOP_REG_DRIVE_CONFIG: regs_next.drv_b = host_wdata;
            default: regs_next.out_b = regs_reg.out_b;
          endcase
        end
        `IOP_PORT_C: begin
          case (reg_code)
            `IOP_REG_OUTPUT_VALUE: regs_next.out_c = host_wdata;
            `IOP_REG_DIRECTION: regs_next.dir_c = host_wdata;
            `IOP_REG_DRIVE_CONFIG: regs_next.drv_c = host_wdata;
            default: regs_next.out_c = regs_reg.out_c;
          endcase
        end
        `IOP_PORT_D: begin
          // Upper bits of port D do not exist
          case (reg_code)
            `IOP_REG_OUTPUT_VALUE: regs_next.out_d = host_wdata[2:0];
            `IOP_REG_DIRECTION: regs_next.dir_d = host_wdata[2:0];
            `IOP_REG_DRIVE_CONFIG: regs_next.drv_d = host_wdata[2:0];
            default: regs_next.out_d = regs_reg.out_d;
          endcase
        end
        default: regs_next.out_b = regs_reg.out_b;
      endcase
    end

    // Read sees register values from before a same-edge write
    if (rd) begin
      case (port_code)
        `IOP_PORT_B: regs_next.rdata = b_rd_word;
        `IOP_PORT_C: regs_next.rdata = c_rd_word;
        `IOP_PORT_D: regs_next.rdata = d_rd_word;
        default: regs_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regs_reg.out_b <= `IOP_RST_OUTPUT_VALUE;
      regs_reg.out_c <= `IOP_RST_OUTPUT_VALUE;
      regs_reg.out_d <= 3'h0;
      // Pins come up as inputs until the host sets a direction
      regs_reg.dir_b <= `IOP_RST_DIRECTION;
      regs_reg.dir_c <= `IOP_RST_DIRECTION;
      regs_reg.dir_d <= 3'h0;
      regs_reg.drv_b <= `IOP_RST_DRIVE_CONFIG;
      regs_reg.drv_c <= `IOP_RST_DRIVE_CONFIG;
      regs_reg.drv_d <= 3'h0;
      regs_reg.rdata <= `IOP_RST_RDATA;
      regs_reg.rvalid <= 1'b0;
      regs_reg.d_array_in <= 3'h0;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // Read data holds until the next read
  assign host_rdata = regs_reg.rdata;
  assign host_rvalid = regs_reg.rvalid;
  assign d_array_input = regs_reg.d_array_in;

  // Port B: eight pins, AB or BC macrocells
  iop_pin_driver #(
    .W(8),
    .OD_MASK(`IOP_B_OD_MASK),
    .SLEW_MASK(`IOP_B_SLEW_MASK)
  ) u_drv_b (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .data_out(regs_reg.out_b),
    .dir(regs_reg.dir_b),
    .drive_cfg(regs_reg.drv_b),
    .array_sel(b_array_out_sel),
    .array_val(b_array_val),
    .oe_term(oe_term_b),
    .release_all(1'b0),
    .pin_o(port_b_out),
    .pin_oe(port_b_oe),
    .pin_fast(port_b_fast)
  );

  // Port C: programming takes the pins over while active
  iop_pin_driver #(
    .W(8),
    .OD_MASK(`IOP_C_OD_MASK),
    .SLEW_MASK(`IOP_C_SLEW_MASK)
  ) u_drv_c (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .data_out(regs_reg.out_c),
    .dir(regs_reg.dir_c),
    .drive_cfg(regs_reg.drv_c),
    .array_sel(c_array_out_sel),
    .array_val(bc_macrocell_group),
    .oe_term(oe_term_c),
    .release_all(in_system_programming),
    .pin_o(port_c_out),
    .pin_oe(port_c_oe),
    .pin_fast(port_c_fast)
  );

  // Port D: three pins, select terms need no macrocell
  iop_pin_driver #(
    .W(3),
    .OD_MASK(`IOP_D_OD_MASK),
    .SLEW_MASK(`IOP_D_SLEW_MASK)
  ) u_drv_d (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .data_out(regs_reg.out_d),
    .dir(regs_reg.dir_d),
    .drive_cfg(regs_reg.drv_d),
    .array_sel(d_ext_select_sel),
    .array_val(ext_select_terms),
    .oe_term(oe_term_d),
    .release_all(1'b0),
    .pin_o(port_d_out),
    .pin_oe(port_d_oe),
    .pin_fast(port_d_fast)
  );

  // Ports B and C only; port D pins skip the macrocells
  iop_input_macrocell u_imc_b (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin_level(port_b_in),
    .cell_mode(b_input_macrocell_mode),
    .pt_lo(b_imc_pt_lo),
    .pt_hi(b_imc_pt_hi),
    .cell_out(b_imc_q)
  );

  iop_input_macrocell u_imc_c (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin_level(port_c_in),
    .cell_mode(c_input_macrocell_mode),
    .pt_lo(c_imc_pt_lo),
    .pt_hi(c_imc_pt_hi),
    .cell_out(c_imc_q)
  );

  // Macrocell outputs also feed the host readback
  assign b_input_macrocell = b_imc_q;
  assign c_input_macrocell = c_imc_q;

endmodule

// ==== iop_consts.svh ====
// Purpose: Offsets, field positions and reset values of the I/O port block
// Assumes: Host address is five bits: port in [4:3], register in [2:0]
// Notes: Offsets are local to this block's register window
`ifndef IOP_CONSTS_SVH
`define IOP_CONSTS_SVH

// Port and register fields of the host address
`define IOP_ADDR_PORT_HI 4
`define IOP_ADDR_PORT_LO 3
`define IOP_ADDR_REG_HI 2
`define IOP_ADDR_REG_LO 0

// Port codes
`define IOP_PORT_B 2'h0
`define IOP_PORT_C 2'h1
`define IOP_PORT_D 2'h2

// Register codes within a port
`define IOP_REG_PIN_INPUT 3'h0
`define IOP_REG_OUTPUT_VALUE 3'h1
`define IOP_REG_DIRECTION 3'h2
`define IOP_REG_DRIVE_CONFIG 3'h3
`define IOP_REG_OMC_READBACK 3'h4
`define IOP_REG_IMC_READBACK 3'h5

// Reset values
`define IOP_RST_OUTPUT_VALUE 8'h00
`define IOP_RST_DIRECTION 8'h00
`define IOP_RST_DRIVE_CONFIG 8'h00
`define IOP_RST_RDATA 8'h00

// Drive select meaning per bit
`define IOP_B_OD_MASK 8'hf0
`define IOP_B_SLEW_MASK 8'h0f
`define IOP_C_OD_MASK 8'hff
`define IOP_C_SLEW_MASK 8'h00
`define IOP_D_OD_MASK 3'h0
`define IOP_D_SLEW_MASK 3'h7

`endif

// ==== iop_pkg.sv ====
// Purpose: Shared types of the I/O port block
// Assumes: Nothing beyond the consts header
// Notes: Modes of the input macrocells and the top state record
package iop_pkg;

  typedef enum logic [1:0] {
    IOP_IMC_PASS = 2'b00,
    IOP_IMC_REG = 2'b01,
    IOP_IMC_LATCH = 2'b10,
    IOP_IMC_RSVD = 2'b11
  } iop_imc_mode_t;

  typedef struct packed {
    logic [7:0] out_b;
    logic [7:0] out_c;
    logic [2:0] out_d;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [2:0] dir_d;
    logic [7:0] drv_b;
    logic [7:0] drv_c;
    logic [2:0] drv_d;
    logic [7:0] rdata;
    logic rvalid;
    logic [2:0] d_array_in;
  } iop_regs_t;

  typedef struct packed {
    logic [7:0] q;
    logic pt_lo_d;
    logic pt_hi_d;
  } iop_imc_state_t;

endpackage

// ==== iop_input_macrocell.sv ====
// Purpose: Eight input macrocells of one port
// Assumes: Pins and product terms are synchronous to core_clk
// Notes: Low nibble shares one product term, high nibble another
`include "iop_consts.svh"

module iop_input_macrocell
  import iop_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] pin_level,
  input wire logic [15:0] cell_mode,
  input wire logic pt_lo,
  input wire logic pt_hi,
  output logic [7:0] cell_out
);

  iop_imc_state_t st_reg;
  iop_imc_state_t st_next;

  always_comb begin
    logic pt;
    logic pt_d;
    iop_imc_mode_t mode;
    pt = 1'b0;
    pt_d = 1'b0;
    mode = IOP_IMC_PASS;
    st_next = st_reg;
    st_next.pt_lo_d = pt_lo;
    st_next.pt_hi_d = pt_hi;
    for (int i = 0; i < 8; i++) begin
      pt = (i < 4) ? pt_lo : pt_hi;
      pt_d = (i < 4) ? st_reg.pt_lo_d : st_reg.pt_hi_d;
      mode = iop_imc_mode_t'(cell_mode[2*i +: 2]);
      case (mode)
        IOP_IMC_PASS: st_next.q[i] = pin_level[i];
        IOP_IMC_REG: begin
          // Rising edge of the clocking term captures the pin
          if (pt && !pt_d) begin
            st_next.q[i] = pin_level[i];
          end
        end
        IOP_IMC_LATCH: begin
          if (pt) begin
            st_next.q[i] = pin_level[i];
          end
        end
        default: st_next.q[i] = pin_level[i];
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cell_out = st_reg.q;

endmodule

// ==== iop_pin_driver.sv ====
// Purpose: Output multiplexer and driver control of one port
// Assumes: Array values and enable terms are synchronous to core_clk
// Notes: Open drain pins only ever drive low
`include "iop_consts.svh"

module iop_pin_driver #(
  parameter int W = 8,
  parameter logic [W-1:0] OD_MASK = '0,
  parameter logic [W-1:0] SLEW_MASK = '0
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] data_out,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] drive_cfg,
  input wire logic [W-1:0] array_sel,
  input wire logic [W-1:0] array_val,
  input wire logic [W-1:0] oe_term,
  input wire logic release_all,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] pin_fast
);

  typedef struct packed {
    logic [W-1:0] o;
    logic [W-1:0] oe;
    logic [W-1:0] fast;
  } iop_drv_state_t;

  iop_drv_state_t st_reg;
  iop_drv_state_t st_next;

  always_comb begin
    logic [W-1:0] val;
    logic [W-1:0] en;
    logic [W-1:0] od;
    // Array-driven bits ignore the output value register
    val = (array_sel & array_val) | (~array_sel & data_out);
    // Without an enable term the direction bit alone decides
    en = oe_term | dir;
    od = drive_cfg & OD_MASK;
    st_next.o = val & ~od;
    st_next.oe = release_all ? '0 : (en & (~od | ~val));
    st_next.fast = drive_cfg & SLEW_MASK;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_o = st_reg.o;
  assign pin_oe = st_reg.oe;
  assign pin_fast = st_reg.fast;

endmodule

// ==== iop_properties.sv ====
// Purpose: Port-level assertions of the I/O port block
// Assumes: Bound into iop_top, one clock domain
// Notes: Pin outputs lag their causes by one cycle
module iop_properties (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic host_sel,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_b_oe,
  input wire logic [7:0] port_c_oe,
  input wire logic [2:0] port_d_in,
  input wire logic [7:0] oe_term_b,
  input wire logic in_system_programming,
  input wire logic [2:0] d_array_input
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Write wins over read on the same edge
  wire logic rd_go = host_sel && host_rd && !host_wr;

  rd_answer_a: assert property (rd_go |=> host_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (host_rvalid |-> $past(rd_go))
    else $error("read valid without read");
  pin_read_a: assert property (rd_go && host_addr == 5'h00 |=> host_rdata == $past(port_b_in))
    else $error("pin input read wrong");
  d_upper_a: assert property (rd_go && host_addr[4:3] == 2'h2 |=> host_rdata[7:3] == 5'h00)
    else $error("port d upper bits set");
  unmapped_zero_a: assert property (rd_go && host_addr[4:3] == 2'h3 |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Low nibble of B has no open drain, so the term alone forces drive
  oe_term_a: assert property ($past(arst_n) |-> (($past(oe_term_b) & ~port_b_oe) & 8'h0f) == 8'h00)
    else $error("enable term ignored");
  isp_release_a: assert property ($past(arst_n) && $past(in_system_programming) |-> port_c_oe == 8'h00)
    else $error("port c driven in programming");
  d_direct_a: assert property ($past(arst_n) |-> d_array_input == $past(port_d_in))
    else $error("port d array input wrong");
endmodule

// ==== iop_board_model.sv ====
// Purpose: Board pins around the I/O port block
// Assumes: An undriven pin takes the level of an outside source
// Notes: Port C source stands for the open drain pull-ups
module iop_board_model (
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe,
  input wire logic [7:0] port_c_out,
  input wire logic [7:0] port_c_oe,
  input wire logic [2:0] port_d_out,
  input wire logic [2:0] port_d_oe,
  input wire logic [7:0] ext_b,
  input wire logic [7:0] ext_c,
  input wire logic [2:0] ext_d,
  output logic [7:0] port_b_in,
  output logic [7:0] port_c_in,
  output logic [2:0] port_d_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Outside sources yield to a driven pin, never fight it
  assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & ext_b);
  assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & ext_c);
  assign port_d_in = (port_d_oe & port_d_out) | (~port_d_oe & ext_d);
endmodule

// ==== testbench.sv ====
// Purpose: Directed tests of the I/O port block
// Assumes: Pins resolved by iop_board_model
// Notes: Host strobes are held up to the taking edge
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, arst_n, host_sel, host_wr, host_rd, host_rvalid, in_system_programming;
  logic b_imc_pt_lo, b_imc_pt_hi, c_imc_pt_lo, c_imc_pt_hi;
  logic [4:0] host_addr;
  logic [7:0] host_wdata, host_rdata, ab_macrocell_group, bc_macrocell_group, oe_term_b, oe_term_c;
  logic [7:0] b_array_out_sel, b_use_bc_group, c_array_out_sel, ext_b, ext_c;
  logic [7:0] port_b_in, port_b_out, port_b_oe, port_b_fast, b_input_macrocell;
  logic [7:0] port_c_in, port_c_out, port_c_oe, port_c_fast, c_input_macrocell;
  logic [2:0] port_d_in, port_d_out, port_d_oe, port_d_fast, d_array_input;
  logic [2:0] ext_select_terms, oe_term_d, d_ext_select_sel, ext_d;
  logic [15:0] b_input_macrocell_mode, c_input_macrocell_mode;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  iop_top uut (.*);
  iop_board_model board (.*);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      report_and_stop;
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    host_sel <= 1'b1;
    host_wr <= w;
    host_rd <= !w;
    host_addr <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_sel <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    #1;
    chk("rvalid", 8'h01, {7'h00, host_rvalid});
    chk("rdata", e, host_rdata);
    @(posedge core_clk);
  endtask

  task automatic look;
    @(posedge core_clk);
    #1;
  endtask

  task automatic t_reset;
    for (int a = 1; a < 20; a++) begin
      if (a[2:0] inside {3'h1, 3'h2, 3'h3}) rd(a[4:0], 8'h00);
    end
    chk("oe", 8'h00, port_b_oe | port_c_oe | {5'h00, port_d_oe});
  endtask

  task automatic t_host_io;
    wr(5'h02, 8'h07);
    wr(5'h01, 8'ha5);
    look;
    chk("b_oe", 8'h07, port_b_oe);
    chk("b_out", 8'h05, port_b_out & port_b_oe);
    @(posedge core_clk);
    rd(5'h00, 8'h5d);
    rd(5'h01, 8'ha5);
    rd(5'h02, 8'h07);
  endtask

  task automatic t_array;
    bc_macrocell_group <= 8'h02;
    b_use_bc_group <= 8'h02;
    b_array_out_sel <= 8'h03;
    look;
    chk("b_mux", 8'h02, port_b_out & 8'h03);
    @(posedge core_clk);
    rd(5'h04, 8'h02);
    rd(5'h0c, 8'h02);
  endtask

  task automatic t_oe_term;
    wr(5'h02, 8'h00);
    oe_term_b <= 8'h04;
    oe_term_c <= 8'h01;
    oe_term_d <= 3'h1;
    look;
    chk("b_oe", 8'h04, port_b_oe);
    @(posedge core_clk);
    oe_term_b <= 8'h00;
    look;
    chk("b_oe", 8'h00, port_b_oe);
    @(posedge core_clk);
  endtask

  task automatic t_port_d;
    wr(5'h12, 8'hff);
    rd(5'h12, 8'h07);
    wr(5'h13, 8'hff);
    ext_select_terms <= 3'h2;
    d_ext_select_sel <= 3'h2;
    look;
    chk("d_out", 8'h02, {5'h00, port_d_out});
    chk("d_fast", 8'h07, {5'h00, port_d_fast});
    chk("d_oe", 8'h07, {5'h00, port_d_oe});
    @(posedge core_clk);
    rd(5'h10, 8'h02);
    rd(5'h14, 8'h02);
    rd(5'h15, 8'h02);
  endtask

  task automatic t_open_drain;
    wr(5'h0a, 8'hff);
    wr(5'h09, 8'h0f);
    wr(5'h0b, 8'hff);
    wr(5'h03, 8'hff);
    look;
    chk("b_fast", 8'h0f, port_b_fast);
    chk("c_out", 8'h00, port_c_out);
    chk("c_fast", 8'h00, port_c_fast);
    @(posedge core_clk);
    rd(5'h08, 8'h0f);
    in_system_programming <= 1'b1;
    look;
    chk("c_oe", 8'h00, port_c_oe);
    @(posedge core_clk);
    rd(5'h08, 8'hff);
    in_system_programming <= 1'b0;
  endtask

  task automatic t_readback;
    rd(5'h18, 8'h00);
    rd(5'h06, 8'h00);
    rd(5'h05, 8'h5a);
    // Low nibble registered, high nibble passes straight through
    b_input_macrocell_mode <= 16'h0055;
    b_imc_pt_lo <= 1'b1;
    repeat (3) @(posedge core_clk);
    b_imc_pt_lo <= 1'b0;
    ext_b <= 8'ha5;
    repeat (2) @(posedge core_clk);
    rd(5'h05, 8'haa);
    b_imc_pt_lo <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(5'h05, 8'ha5);
  endtask

  task automatic t_latch;
    // Low nibble of port C released and latched while the term is high
    wr(5'h0a, 8'hf0);
    c_input_macrocell_mode <= 16'h00aa;
    c_imc_pt_lo <= 1'b1;
    repeat (2) @(posedge core_clk);
    c_imc_pt_lo <= 1'b0;
    ext_c <= 8'hf5;
    look;
    look;
    chk("b_imc", 8'ha5, b_input_macrocell);
    chk("c_imc", 8'h0f, c_input_macrocell);
    @(posedge core_clk);
    c_imc_pt_lo <= 1'b1;
    look;
    chk("c_imc", 8'h05, c_input_macrocell);
    @(posedge core_clk);
    rd(5'h0d, 8'h05);
  endtask

  initial begin
    arst_n = 1'b0;
    {host_sel, host_wr, host_rd, in_system_programming} = 4'h0;
    {b_imc_pt_lo, b_imc_pt_hi, c_imc_pt_lo, c_imc_pt_hi} = 4'h0;
    host_addr = 5'h00;
    {host_wdata, ab_macrocell_group, bc_macrocell_group, oe_term_b, oe_term_c} = 40'h0;
    {b_array_out_sel, b_use_bc_group, c_array_out_sel} = 24'h0;
    {ext_select_terms, oe_term_d, d_ext_select_sel} = 9'h0;
    {b_input_macrocell_mode, c_input_macrocell_mode} = 32'h0;
    ext_b = 8'h5a;
    ext_c = 8'hff;
    ext_d = 3'h5;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset;
    t_host_io;
    t_array;
    t_oe_term;
    t_port_d;
    t_open_drain;
    t_readback;
    t_latch;
    report_and_stop;
  end
endmodule

bind iop_top iop_properties chk_i (.*);
